/* File: src/bus_area_cfg_pkg.sv */
/*
  constants shared by the area configuration block and its access timer:
  register offsets, reset values, field positions, masks and state counts.
  assumes a 32-bit apb register bus with 12 decoded address bits.
*/
package bus_area_cfg_pkg;

  localparam int          ADDR_W              = 12;
  localparam int          DATA_W              = 32;
  localparam int          CNT_W               = 4;

  localparam logic [11:0] AREA_CTRL_OFFSET    = 12'h000;
  localparam logic [11:0] READ_WAIT_OFFSET    = 12'h004;

  localparam logic [15:0] AREA_CTRL_RESET     = 16'h0000;
  localparam logic [15:0] READ_WAIT_RESET     = 16'hffff;
  localparam logic [15:0] AREA_CTRL_RW_MASK   = 16'hf800;
  localparam logic [15:0] READ_WAIT_RW_MASK   = 16'hff02;
  localparam logic [15:0] READ_WAIT_ONES      = 16'h00fd;

  localparam int          DYN_MEM_BIT         = 15;
  localparam int          MUX_IO_BIT          = 14;
  localparam int          WARP_BIT            = 13;
  localparam int          DUTY_BIT            = 12;
  localparam int          STROBE_SCHEME_BIT   = 11;
  localparam int          READ_PITCH_MSB      = 15;
  localparam int          READ_PITCH_LSB      = 8;
  localparam int          WRITE_PITCH_BIT     = 1;

  localparam logic [2:0]  AREA0               = 3'h0;
  localparam logic [2:0]  AREA1               = 3'h1;
  localparam logic [2:0]  AREA2               = 3'h2;
  localparam logic [2:0]  AREA5               = 3'h5;
  localparam logic [2:0]  AREA6               = 3'h6;
  localparam logic [2:0]  AREA7               = 3'h7;

  localparam logic [3:0]  STATES_ONE          = 4'h1;
  localparam logic [3:0]  STATES_TWO          = 4'h2;
  localparam logic [3:0]  STATES_THREE        = 4'h3;
  localparam logic [3:0]  STATES_FOUR         = 4'h4;

endpackage : bus_area_cfg_pkg

/* File: src/access_timing_if.sv */
/*
  carrier between the configuration block and its access timer.
  assumes both ends run on the same pclk.
*/
`timescale 1ns/1ns
interface access_timing_if;
  logic       start;    // one-cycle request to time an access
  logic [3:0] states;   // fixed states of the access
  logic       sample;   // hold-off input is sampled in the last fixed state
  logic       busy;     // access in progress
  logic       waiting;  // an inserted hold-off wait state is running
  logic       done;     // one-cycle pulse after the last state

  modport requester (output start, states, sample, input busy, waiting, done);
  modport timer     (input start, states, sample, output busy, waiting, done);
endinterface : access_timing_if

/* File: src/access_state_timer.sv */
/*
  counts the states of one external access: the fixed states, then one
  inserted wait state per cycle while the hold-off input is sampled low.
  assumes hold_off_n is synchronous to pclk and start comes only when idle.
*/
`timescale 1ns/1ns
module access_state_timer
  import bus_area_cfg_pkg::*;
(
  input  wire logic      pclk,        // system clock
  input  wire logic      presetn,     // power-on reset, active low
  input  wire logic      hold_off_n,  // external hold-off input, low inserts waits
  access_timing_if.timer tif          // timing request and status
);

  typedef enum logic {idle_st, run_st} timer_state_t;

  timer_state_t      state;
  logic [CNT_W-1:0]  count;
  logic              sample;

  wire last_fixed = (state == run_st) && (count == STATES_ONE);
  wire hold       = last_fixed && sample && !hold_off_n;
  wire finish     = last_fixed && !hold;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= idle_st;
      count       <= '0;
      sample      <= 1'b0;
      tif.waiting <= 1'b0;
      tif.done    <= 1'b0;
    end else begin
      tif.done    <= finish;
      tif.waiting <= hold;                                     // R20
      unique case (state)
        idle_st: if (tif.start) begin
          state  <= run_st;
          count  <= tif.states;
          sample <= tif.sample;
        end
        run_st: begin
          if (finish) state <= idle_st;
          if (!last_fixed) count <= count - STATES_ONE;
        end
      endcase
    end
  end

  assign tif.busy = (state == run_st);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_inserts_wait_a: assert property (                     // R20
    last_fixed && sample && !hold_off_n |=> tif.busy && tif.waiting)
    else $error("hold-off low did not insert a wait state");
  done_after_busy_a: assert property (                       // R20
    tif.waiting && hold_off_n |=> tif.done && !tif.busy)
    else $error("released hold-off did not end the access");
  unsampled_no_wait_a: assert property (                     // R20
    tif.waiting |-> $past(sample))
    else $error("wait inserted while sampling disabled");
  one_state_pulse_a: assert property (                       // R10
    tif.start && !tif.busy && tif.states == STATES_ONE && !tif.sample
    |=> tif.busy ##1 tif.done)
    else $error("single-state access did not end after one state");
  two_state_free_a: assert property (                        // R10
    tif.start && !tif.busy && tif.states == STATES_TWO && !tif.sample
    |=> tif.busy [*2] ##1 tif.done)
    else $error("two-state access length wrong");

  cover_wait_c: cover property (tif.waiting ##1 tif.waiting);
  cover_done_c: cover property (tif.start ##[1:20] tif.done);

endmodule : access_state_timer

/* File: src/bus_area_config_read_wait_control.sv */
/*
  area function and read wait state configuration of the external bus
  controller, an apb slave with two registers, plus the per-access state
  selection that feeds the access timer.
  assumes apb signals and the access request inputs are synchronous to pclk,
  and that presetn is the power-on reset only (manual reset and standby
  never reach it, so the settings survive them).
*/
`timescale 1ns/1ns
// Contract
// R1 - area control resets to zero, power-on only
// R2 - bit 15 makes area 1 dynamic memory
// R3 - bit 14 makes area 6 multiplexed io
// R4 - bit 13 allows external/internal access overlap
// R5 - bit 12 selects strobe high duty 35%
// R6 - bit 11 selects byte strobe scheme
// R7 - area control bits 10-0 read zero
// R8 - read wait resets to all ones, power-on
// R9 - bits 15-8 enable hold-off per area
// R10 - areas 1,3,4,5,7: one or two states
// R11 - areas 0,2,6: one plus long waits
// R12 - dynamic memory column read pitch from bit
// R13 - refresh uses refresh states, ignores hold-off
// R14 - multiplexed io read always four states
// R15 - on-chip peripheral read three states fixed
// R16 - on-chip rom and ram one state
// R17 - read wait bits 7-2,0 read one
// R18 - write pitch bit sets column write states
// R19 - software clears write pitch only for dram
// R20 - hold-off low repeats one wait state
module bus_area_config_read_wait_control
  import bus_area_cfg_pkg::*;
#(
  parameter int LONG_W    = 2,   // width of the long wait count
  parameter int REFRESH_W = 2    // width of the refresh wait count
) (
  input  wire logic                 pclk,                      // system clock
  input  wire logic                 presetn,                   // power-on reset
  input  wire logic                 psel,                      // apb select
  input  wire logic                 penable,                   // apb enable
  input  wire logic                 pwrite,                    // apb write
  input  wire logic [ADDR_W-1:0]    paddr,                     // apb byte address
  input  wire logic [DATA_W-1:0]    pwdata,                    // apb write data
  input  wire logic [3:0]           pstrb,                     // apb byte strobes
  output logic      [DATA_W-1:0]    prdata,                    // apb read data
  output logic                      pready,                    // apb ready
  output logic                      pslverr,                   // apb error
  input  wire logic                 acc_req,                   // access request pulse
  input  wire logic [2:0]           acc_area,                  // area of the access
  input  wire logic                 acc_write,                 // access is a write
  input  wire logic                 acc_onchip,                // on-chip space
  input  wire logic                 acc_refresh,               // refresh cycle
  input  wire logic [LONG_W-1:0]    long_wait_states,          // long waits, areas 0 2 6
  input  wire logic [REFRESH_W-1:0] refresh_extra_states,      // refresh wait count
  input  wire logic                 hold_off_n,                // hold-off input
  output logic                      area1_dynamic_mem_enable,  // area 1 is dram
  output logic                      area6_mux_io_enable,       // area 6 is muxed io
  output logic                      overlap_enable,            // warp overlap allowed
  output logic                      read_strobe_duty_select,   // 35% high duty
  output logic                      byte_strobe_scheme_select, // byte strobe scheme
  output logic                      acc_busy,                  // access running
  output logic                      acc_waiting,               // hold-off wait state
  output logic                      acc_done                   // access finished pulse
);

  logic [15:0] area_function_control;
  logic [15:0] read_wait_state_control;

  // apb decode
  wire        setup_phase    = psel && !penable;
  wire        access_edge    = psel && penable && pready;
  wire        hit_area       = (paddr == AREA_CTRL_OFFSET);
  wire        hit_wait       = (paddr == READ_WAIT_OFFSET);
  wire        hit_any        = hit_area || hit_wait;
  wire        wr_area        = access_edge && pwrite && hit_area;
  wire        wr_wait        = access_edge && pwrite && hit_wait;
  wire [15:0] lane_mask      = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  wire [15:0] next_area_function_control =
    ((pwdata[15:0] & lane_mask) | (area_function_control & ~lane_mask))
    & AREA_CTRL_RW_MASK;                                                 // R7
  wire [15:0] next_read_wait_state_control =
    (((pwdata[15:0] & lane_mask) | (read_wait_state_control & ~lane_mask))
    & READ_WAIT_RW_MASK) | READ_WAIT_ONES;                               // R17

  wire [15:0] read_value =
    hit_area ? area_function_control :
    hit_wait ? read_wait_state_control : 16'h0000;
  wire [DATA_W-1:0] next_prdata = {{(DATA_W-16){1'b0}}, read_value};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_function_control <= AREA_CTRL_RESET;                          // R1
    end else if (wr_area) begin
      area_function_control <= next_area_function_control;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_wait_state_control <= READ_WAIT_RESET;                        // R8
    end else if (wr_wait) begin
      read_wait_state_control <= next_read_wait_state_control;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !hit_any;
      prdata  <= (setup_phase && !pwrite) ? next_prdata : '0;
    end
  end

  // configuration fields
  wire dyn_mem   = area_function_control[DYN_MEM_BIT];                   // R2
  wire mux_io    = area_function_control[MUX_IO_BIT];                    // R3
  wire [7:0] read_pitch = read_wait_state_control[READ_PITCH_MSB:READ_PITCH_LSB];
  wire write_pitch = read_wait_state_control[WRITE_PITCH_BIT];

  assign area1_dynamic_mem_enable  = dyn_mem;
  assign area6_mux_io_enable       = mux_io;
  assign overlap_enable            = area_function_control[WARP_BIT];    // R4
  assign read_strobe_duty_select   = area_function_control[DUTY_BIT];    // R5
  assign byte_strobe_scheme_select = area_function_control[STROBE_SCHEME_BIT]; // R6

  // per-access state selection
  wire       area_bit     = read_pitch[acc_area];                        // R9
  wire       is_a1        = (acc_area == AREA1);
  wire       is_long_area = (acc_area == AREA0) || (acc_area == AREA2) ||
                            (acc_area == AREA6);
  wire       onchip_fast  = acc_onchip && ((acc_area == AREA0) || (acc_area == AREA7));
  wire       onchip_per   = acc_onchip && (acc_area == AREA5);
  wire       mux_access   = mux_io && (acc_area == AREA6);
  wire       dram_access  = dyn_mem && is_a1;
  wire [3:0] long_count   = 4'(long_wait_states);
  wire [3:0] refresh_count = 4'(refresh_extra_states);

  wire [3:0] refresh_states = read_pitch[AREA1] ? STATES_TWO + refresh_count
                                                : STATES_ONE;            // R13
  wire [3:0] pitch_states   = area_bit ? STATES_TWO : STATES_ONE;        // R10 R12
  wire [3:0] long_states    = STATES_ONE + long_count;                   // R11
  wire [3:0] write_states   = (dram_access && !write_pitch) ? STATES_ONE
                                                            : STATES_TWO; // R18
  wire       write_sample   = !(dram_access && !write_pitch);            // R18

  wire [3:0] sel_states =
    acc_refresh  ? refresh_states :
    onchip_fast  ? STATES_ONE     :                                      // R16
    onchip_per   ? STATES_THREE   :                                      // R15
    mux_access   ? STATES_FOUR    :                                      // R14
    acc_write    ? write_states   :
    is_long_area ? long_states    : pitch_states;
  wire       sel_sample =
    acc_refresh  ? 1'b0 :                                                // R13
    onchip_fast  ? 1'b0 :
    onchip_per   ? 1'b0 :
    mux_access   ? 1'b1 :
    acc_write    ? write_sample : area_bit;                              // R9 R11

  access_timing_if tif ();

  wire take_req = acc_req && !tif.busy && !tif.start;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif.start  <= 1'b0;
      tif.states <= STATES_ONE;
      tif.sample <= 1'b0;
    end else begin
      tif.start  <= take_req;
      if (take_req) begin
        tif.states <= sel_states;
        tif.sample <= sel_sample;
      end
    end
  end

  access_state_timer timer_u (
    .pclk       (pclk),
    .presetn    (presetn),
    .hold_off_n (hold_off_n),
    .tif        (tif.timer)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_busy    <= 1'b0;
      acc_waiting <= 1'b0;
      acc_done    <= 1'b0;
    end else begin
      acc_busy    <= tif.busy;
      acc_waiting <= tif.waiting;
      acc_done    <= tif.done;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (
    setup_phase |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  unmapped_error_a: assert property (
    setup_phase && !hit_any |=> pslverr && prdata == '0)
    else $error("unmapped access not flagged");
  area_reserved_a: assert property (                          // R7
    area_function_control[10:0] == 11'h000)
    else $error("area control reserved bits not zero");
  wait_ones_a: assert property (                              // R17
    (read_wait_state_control & READ_WAIT_ONES) == READ_WAIT_ONES)
    else $error("read wait reserved bits not one");
  area_write_a: assert property (                             // R2
    wr_area && pstrb[1] |=> dyn_mem == $past(pwdata[DYN_MEM_BIT]))
    else $error("area control write lost");
  mux_four_a: assert property (                               // R14
    take_req && mux_access && !acc_refresh && !acc_onchip
    |=> tif.start && tif.states == STATES_FOUR && tif.sample)
    else $error("multiplexed io access not four states");
  peripheral_three_a: assert property (                       // R15
    take_req && onchip_per && !acc_refresh
    |=> tif.states == STATES_THREE && !tif.sample)
    else $error("peripheral access not three fixed states");
  refresh_ignore_a: assert property (                         // R13
    take_req && acc_refresh |=> !tif.sample)
    else $error("refresh sampled the hold-off input");
  onchip_one_a: assert property (                             // R16
    take_req && onchip_fast && !acc_refresh
    |=> ##1 tif.busy ##1 tif.done)
    else $error("on-chip access not one state");
  cfg_follow_a: assert property (                             // R3 R4 R5 R6
    wr_area && pstrb[1]
    |=> {mux_io, overlap_enable, read_strobe_duty_select, byte_strobe_scheme_select}
        == $past(pwdata[MUX_IO_BIT:STROBE_SCHEME_BIT]))
    else $error("area function fields not taken from the write");
  wait_write_a: assert property (                             // R9 R18
    wr_wait && pstrb[1] && pstrb[0]
    |=> read_pitch == $past(pwdata[READ_PITCH_MSB:READ_PITCH_LSB])
        && write_pitch == $past(pwdata[WRITE_PITCH_BIT]))
    else $error("read wait fields not taken from the write");
  pitch_select_a: assert property (                           // R10 R12
    take_req && !acc_refresh && !acc_write && !is_long_area && !onchip_per && !onchip_fast
    |=> tif.states == ($past(area_bit) ? STATES_TWO : STATES_ONE)
        && tif.sample == $past(area_bit))
    else $error("read pitch not taken from the area bit");
  long_select_a: assert property (                            // R11
    take_req && is_long_area && !mux_access && !onchip_fast && !acc_refresh && !acc_write
    |=> tif.states == STATES_ONE + $past(long_count) && tif.sample == $past(area_bit))
    else $error("long wait area states wrong");
  dram_write_a: assert property (                             // R18
    take_req && acc_write && dram_access && !write_pitch && !acc_refresh
    |=> tif.states == STATES_ONE && !tif.sample)
    else $error("short pitch dram write not one state");
  refresh_wait_a: assert property (                           // R13
    take_req && acc_refresh && read_pitch[AREA1]
    |=> tif.states == STATES_TWO + $past(refresh_count))
    else $error("refresh wait count not inserted");

  write_cover_c: cover property (wr_wait ##1 !write_pitch);
  dram_cover_c: cover property (take_req && dram_access && !acc_write);
  wait_cover_c: cover property (acc_waiting ##1 acc_done);

endmodule : bus_area_config_read_wait_control

/* File: verification/hold_off_responder.sv */
/*
  far-side model: an external memory that holds the hold-off line low
  for a commanded number of its first busy cycles of each access.
  assumes it shares pclk with the block and the line has a pull-up.
*/
`timescale 1ns/1ns
module hold_off_responder (
  input  wire logic       pclk,        // system clock
  input  wire logic       presetn,     // power-on reset
  input  wire logic       acc_busy,    // access running
  input  wire logic       acc_done,    // access finished
  input  wire logic [1:0] wait_count,  // busy cycles this memory stays slow
  output logic            hold_off_n   // hold-off line, low holds the access
);
  logic [1:0] slow_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt <= 2'h0;
    end else if (acc_done) begin
      slow_cnt <= 2'h0;
    end else if (acc_busy && slow_cnt != 2'h3) begin
      slow_cnt <= slow_cnt + 2'h1;
    end
  end

  // low for the first wait_count cycles of acc_busy; otherwise the pull-up wins
  assign hold_off_n = !(acc_busy && slow_cnt < wait_count);
endmodule : hold_off_responder

/* File: verification/bus_area_config_read_wait_control_tb.sv */
/*
  self-checking bench: apb register checks and timed accesses per area.
  assumes the far side is the hold-off responder model.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module bus_area_config_read_wait_control_tb;
  import bus_area_cfg_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              acc_req, acc_write, acc_onchip, acc_refresh, hold_off_n;
  logic [2:0]        acc_area;
  logic [1:0]        long_w, refr_w, wait_count;
  logic [4:0]        cfg;
  logic              acc_busy, acc_waiting, acc_done;
  logic [31:0]       rd_q[$];
  logic [11:0]       acc_q[$];
  logic [11:0]       acc_note;
  logic [31:0]       rd_note;
  logic [7:0]        busy_cnt;
  logic [3:0]        wait_cnt;
  integer            seed, err_total, tests_run, cyc;

  bus_area_config_read_wait_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_req(acc_req), .acc_area(acc_area), .acc_write(acc_write),
    .acc_onchip(acc_onchip), .acc_refresh(acc_refresh), .long_wait_states(long_w),
    .refresh_extra_states(refr_w), .hold_off_n(hold_off_n),
    .area1_dynamic_mem_enable(cfg[4]), .area6_mux_io_enable(cfg[3]),
    .overlap_enable(cfg[2]), .read_strobe_duty_select(cfg[1]),
    .byte_strobe_scheme_select(cfg[0]), .acc_busy(acc_busy),
    .acc_waiting(acc_waiting), .acc_done(acc_done));

  hold_off_responder partner (
    .pclk(pclk), .presetn(presetn), .acc_busy(acc_busy), .acc_done(acc_done),
    .wait_count(wait_count), .hold_off_n(hold_off_n));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    `CHK("pslverr", err, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0, err);
  endtask : rd

  function automatic logic [11:0] states(input logic [2:0] ar, input logic wr, oc, rf,
      input logic [1:0] l, r, k, input logic [15:0] ctl, rw);
    int n, w;
    logic smp;
    smp = rw[8 + ar];
    n = smp ? 2 : 1;
    if (ar == 3'd0 || ar == 3'd2 || ar == 3'd6) n = 1 + l;
    if (wr) begin
      smp = !(ctl[15] && ar == 3'd1 && !rw[1]);
      n = smp ? 2 : 1;
    end
    if (ar == 3'd6 && ctl[14]) begin
      smp = 1'b1;
      n = 4;
    end
    if (oc && ar == 3'd5) n = 3;
    if (oc && (ar == 3'd0 || ar == 3'd7)) n = 1;
    if (rf) n = rw[9] ? 2 + r : 1;
    if (rf || (oc && (ar == 3'd0 || ar == 3'd5 || ar == 3'd7))) smp = 1'b0;
    // the memory is slow for its first k cycles of acc_busy, which trails the
    // access by one cycle: only lows reaching the last fixed state add waits
    w = (smp && n >= 2 && k + 2 > n) ? k + 2 - n : 0;
    return {w[3:0], 8'(n + w)};
  endfunction : states

  task access(input logic [2:0] ar, input logic wr, oc, rf, input logic [31:0] r,
      input logic [15:0] ctl, rw);
    acc_q.push_back(states(ar, wr, oc, rf, r[3:2], r[5:4], r[1:0], ctl, rw));
    @(posedge pclk);
    acc_req <= 1'b1; acc_area <= ar; acc_write <= wr; acc_onchip <= oc;
    acc_refresh <= rf; long_w <= r[3:2]; refr_w <= r[5:4]; wait_count <= r[1:0];
    @(posedge pclk);
    acc_req <= 1'b0;
    while (acc_done !== 1'b1) @(posedge pclk);
  endtask : access

  task phase(input logic [15:0] ctl, rw);
    int i;
    if (ctl[15]) begin
      apb(1'b1, AREA_CTRL_OFFSET, {16'h0, ctl}, 1'b0);
      apb(1'b1, READ_WAIT_OFFSET, {16'h0, rw}, 1'b0);
    end else begin
      apb(1'b1, READ_WAIT_OFFSET, {16'h0, rw}, 1'b0);
      apb(1'b1, AREA_CTRL_OFFSET, {16'h0, ctl}, 1'b0);
    end
    @(posedge pclk);
    `CHK("config outputs", ctl[15:11], cfg)
    for (i = 0; i < 14; i++) begin
      access(i < 8 ? i[2:0] : (i == 8 ? 3'd0 : i == 9 ? 3'd5 : i == 10 ? 3'd7 :
             i == 13 ? 3'd3 : 3'd1), i > 11, i > 7 && i < 11, i == 11,
             $random(seed), ctl, rw);
    end
  endtask : phase

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rd_note = rd_q.pop_front();
      `CHK("prdata", rd_note, prdata)
    end
    if (acc_done === 1'b1) begin
      acc_note = acc_q.pop_front();
      `CHK("busy states", acc_note[7:0], busy_cnt)
      `CHK("wait states", acc_note[11:8], wait_cnt)
      busy_cnt = 8'd0;
      wait_cnt = 4'd0;
    end else begin
      if (acc_busy === 1'b1) busy_cnt++;
      if (acc_waiting === 1'b1) wait_cnt++;
    end
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    logic [31:0] r;
    seed = 32'hf3a8; err_total = 0; tests_run = 0; cyc = 0; busy_cnt = 8'd0;
    wait_cnt = 4'd0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; acc_req = 1'b0; acc_area = 3'h0; acc_write = 1'b0;
    acc_onchip = 1'b0; acc_refresh = 1'b0; long_w = 2'h0; refr_w = 2'h0;
    wait_count = 2'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(AREA_CTRL_OFFSET, 32'h0000_0000, 1'b0);
    rd(READ_WAIT_OFFSET, 32'h0000_ffff, 1'b0);
    apb(1'b1, AREA_CTRL_OFFSET, 32'hffff_ffff, 1'b0);
    rd(AREA_CTRL_OFFSET, 32'h0000_f800, 1'b0);
    apb(1'b1, READ_WAIT_OFFSET, 32'h0000_0000, 1'b0);
    rd(READ_WAIT_OFFSET, 32'h0000_00fd, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_1234, 1'b1);
    rd(12'h008, 32'h0000_0000, 1'b1);
    r = $random(seed);
    phase({2'b11, r[2:0], 11'h0}, 16'hff02);
    phase({2'b11, r[5:3], 11'h0}, 16'h00fd);
    phase({2'b00, r[8:6], 11'h0}, 16'hff02);
    repeat (3) @(posedge pclk);
    summarize();
  end
endmodule : bus_area_config_read_wait_control_tb
